// ===== rtl/dscp_regs.svh
// constants of the dual serial control port host
`ifndef DSCP_REGS_SVH
`define DSCP_REGS_SVH
`define DSCP_CLK_MHZ 100
`define DSCP_CNT_W 10
`define DSCP_SPI_HALF_NS 50
`define DSCP_SPI_HALF_CYC ((`DSCP_SPI_HALF_NS * `DSCP_CLK_MHZ + 999) / 1000)
`define DSCP_CS_GAP_NS 6250
`define DSCP_CS_GAP_CYC ((`DSCP_CS_GAP_NS * `DSCP_CLK_MHZ + 999) / 1000)
`define DSCP_I2C_Q_NS 900
`define DSCP_I2C_Q_CYC ((`DSCP_I2C_Q_NS * `DSCP_CLK_MHZ + 999) / 1000)
`define DSCP_DEV_HI 5'h06
`define DSCP_GCALL_ADDR 8'h00
`define DSCP_PAGE_REG 7'h00
`define DSCP_PAGE_MASK 8'h01
`define DSCP_SPI_LAST 5'h0F
`define DSCP_SPI_BITS 5'h10
`define DSCP_ACK_BIT 5'h08
`define DSCP_READ_STEP 3'h5
`endif

// ===== rtl/dscp_pkg.sv
// types of the dual serial control port host
`include "dscp_regs.svh"
package dscp_pkg;
  typedef enum logic [2:0] {S_IDLE, S_SPI_CS, S_SPI_BIT, S_SPI_END, S_WAIT, S_I2C_EL} dscp_fsm_type;
  typedef enum logic [1:0] {EL_START, EL_BYTE, EL_STOP} dscp_el_type;
  typedef struct packed {
    logic rd;
    logic gcall;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dscp_cmd_type;
  typedef struct packed {
    logic valid;
    logic nack;
    logic [7:0] rdata;
  } dscp_rsp_type;
  typedef struct packed {
    dscp_el_type el;
    logic [8:0] tx;
  } dscp_elem_type;
  typedef struct packed {
    dscp_fsm_type fsm;
    dscp_el_type el;
    logic [`DSCP_CNT_W-1:0] cnt;
    logic [1:0] ph;
    logic [4:0] bitn;
    logic [2:0] step;
    logic [15:0] sh;
    logic [8:0] rx;
    dscp_cmd_type cmd;
    dscp_rsp_type rsp;
    logic spi;
    logic [1:0] asel;
    logic ready;
    logic page;
    logic multifunction_pin_0;
    logic multifunction_pin_1;
    logic multifunction_pin_3;
    logic lo;
    logic scl_oe;
    logic sda_oe;
    logic miso1;
    logic miso2;
    logic sda1;
    logic sda2;
    logic scl1;
    logic scl2;
  } dscp_state_type;
endpackage : dscp_pkg

// ===== rtl/dscp_host.sv
// host controller for the codec control port, SPI or I2C
`timescale 1ns/1ps
`include "dscp_regs.svh"
module dscp_host
  import dscp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic MODE_SPI,
  input wire logic [1:0] ADDR_STRAP,
  input wire logic CMD_VALID,
  input wire dscp_cmd_type CMD,
  output logic CMD_READY,
  output dscp_rsp_type RSP,
  output logic PAGE_SEL,
  output logic SELECT_PIN,
  output logic MULTIFUNCTION_PIN_0,
  output logic MULTIFUNCTION_PIN_1,
  input wire logic MULTIFUNCTION_PIN_2,
  output logic MULTIFUNCTION_PIN_3,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  dscp_state_type s_q;
  dscp_state_type s_d;
  logic [9:0] hgap_q;
  logic [4:0] hedge_q;

  // element at a given step of a transaction
  function automatic dscp_elem_type dscp_plan(input dscp_cmd_type c, input logic [2:0] st,
                                              input logic [1:0] a);
    dscp_elem_type e;
    logic [6:0] dev;
    e.el = EL_BYTE;
    dev = {`DSCP_DEV_HI, a};
    e.tx = {dev, 1'b0, 1'b1};
    case (st)
      3'h0: e.el = EL_START;
      3'h1: begin
        if (c.gcall) e.tx = {`DSCP_GCALL_ADDR, 1'b1};
      end
      3'h2: e.tx = c.gcall ? {c.wdata, 1'b1} : {1'b0, c.addr, 1'b1};
      3'h3: begin
        if (c.gcall) e.el = EL_STOP;
        else if (c.rd) e.el = EL_START;
        else e.tx = {c.wdata, 1'b1};
      end
      3'h4: begin
        if (c.rd) e.tx = {dev, 1'b1, 1'b1};
        else e.el = EL_STOP;
      end
      3'h5: e.tx = 9'h1ff;
      default: e.el = EL_STOP;
    endcase
    return e;
  endfunction : dscp_plan

  always_comb begin
    dscp_elem_type e;
    logic [8:0] rxn;
    logic [7:0] wd;
    logic pg;
    logic tick;
    e = dscp_plan(s_q.cmd, s_q.step + 3'h1, s_q.asel);
    rxn = {s_q.rx[7:0], s_q.sda2};
    wd = (CMD.addr == `DSCP_PAGE_REG && !CMD.gcall) ? (CMD.wdata & `DSCP_PAGE_MASK) : CMD.wdata;
    pg = (s_q.cmd.addr == `DSCP_PAGE_REG) && !s_q.cmd.rd && !s_q.cmd.gcall && !s_q.rsp.nack;
    tick = (s_q.cnt == '0);
    s_d = s_q;
    s_d.miso1 = MULTIFUNCTION_PIN_2;
    s_d.miso2 = s_q.miso1;
    s_d.sda1 = SDA_I;
    s_d.sda2 = s_q.sda1;
    s_d.scl1 = SCL_I;
    s_d.scl2 = s_q.scl1;
    s_d.rsp.valid = 1'b0;
    s_d.cnt = tick ? s_q.cnt : s_q.cnt - 10'h001;
    case (s_q.fsm)
      S_IDLE: begin
        if (CMD_VALID) begin
          s_d.cmd = CMD;
          s_d.cmd.wdata = wd;
          s_d.ready = 1'b0;
          s_d.rsp.nack = 1'b0;
          s_d.rx = '0;
          if (s_q.spi) begin
            s_d.fsm = S_SPI_CS;
            s_d.multifunction_pin_0 = 1'b0;
            s_d.cnt = 10'(`DSCP_SPI_HALF_CYC);
            s_d.sh = {CMD.addr, CMD.rd, wd};
          end else begin
            s_d.fsm = S_I2C_EL;
            s_d.step = 3'h0;
            s_d.el = EL_START;
            s_d.ph = 2'h0;
            s_d.cnt = 10'(`DSCP_I2C_Q_CYC);
            s_d.scl_oe = 1'b1;
          end
        end
      end
      S_SPI_CS: begin
        if (tick) begin
          s_d.fsm = S_SPI_BIT;
          s_d.ph = 2'h0;
          s_d.bitn = 5'h00;
          s_d.multifunction_pin_1 = 1'b1;
          s_d.multifunction_pin_3 = s_q.sh[15];
          s_d.cnt = 10'(`DSCP_SPI_HALF_CYC);
        end
      end
      S_SPI_BIT: begin
        if (tick) begin
          s_d.cnt = 10'(`DSCP_SPI_HALF_CYC);
          if (s_q.ph == 2'h0) begin
            s_d.multifunction_pin_1 = 1'b0;
            s_d.rx = {s_q.rx[7:0], s_q.miso2};
            s_d.sh = {s_q.sh[14:0], 1'b0};
            s_d.ph = 2'h1;
          end else if (s_q.bitn == `DSCP_SPI_LAST) begin
            s_d.fsm = S_SPI_END;
          end else begin
            s_d.bitn = s_q.bitn + 5'h01;
            s_d.ph = 2'h0;
            s_d.multifunction_pin_1 = 1'b1;
            s_d.multifunction_pin_3 = s_q.sh[15];
          end
        end
      end
      S_SPI_END: begin
        if (tick) begin
          // one command byte and one data byte per frame, select rises
          s_d.multifunction_pin_0 = 1'b1;
          s_d.fsm = S_WAIT;
          s_d.cnt = 10'(`DSCP_CS_GAP_CYC);
          s_d.rsp.valid = 1'b1;
          s_d.rsp.rdata = s_q.rx[7:0];
          if (pg) s_d.page = s_q.cmd.wdata[0];
        end
      end
      S_WAIT: begin
        if (tick) begin
          s_d.fsm = S_IDLE;
          s_d.ready = 1'b1;
        end
      end
      S_I2C_EL: begin
        if (tick && !(s_q.ph == 2'h3 && !s_q.scl2)) begin
          s_d.cnt = 10'(`DSCP_I2C_Q_CYC);
          if (s_q.ph != 2'h3) begin
            s_d.ph = s_q.ph + 2'h1;
          end else if (s_q.el == EL_BYTE && s_q.bitn != `DSCP_ACK_BIT) begin
            s_d.rx = rxn;
            s_d.bitn = s_q.bitn + 5'h01;
            s_d.sh = {s_q.sh[14:0], 1'b0};
            s_d.ph = 2'h0;
          end else if (s_q.el == EL_BYTE && rxn[0]
                       && !(s_q.cmd.rd && s_q.step == `DSCP_READ_STEP)) begin
            s_d.rx = rxn;
            s_d.rsp.nack = 1'b1;
            s_d.el = EL_STOP;
            s_d.step = 3'h6;
            s_d.ph = 2'h0;
          end else if (s_q.el == EL_STOP) begin
            s_d.fsm = S_IDLE;
            s_d.ready = 1'b1;
            s_d.rsp.valid = 1'b1;
            if (pg) s_d.page = s_q.cmd.wdata[0];
          end else begin
            s_d.rx = rxn;
            if (s_q.cmd.rd && s_q.step == `DSCP_READ_STEP) s_d.rsp.rdata = rxn[8:1];
            s_d.step = s_q.step + 3'h1;
            s_d.el = e.el;
            s_d.sh = {e.tx, 7'h00};
            s_d.bitn = 5'h00;
            s_d.ph = 2'h0;
          end
          s_d.scl_oe = (s_d.ph < 2'h2);
          if (s_d.ph != 2'h0) begin
            case (s_d.el)
              EL_START: s_d.sda_oe = (s_d.ph == 2'h3);
              EL_STOP: s_d.sda_oe = (s_d.ph != 2'h3);
              default: s_d.sda_oe = !s_d.sh[15];
            endcase
          end
        end
      end
      default: s_d.fsm = S_IDLE;
    endcase
    if (RESET) begin
      s_d = '0;
      s_d.fsm = S_WAIT;
      s_d.cnt = 10'(`DSCP_CS_GAP_CYC);
      s_d.spi = MODE_SPI;
      s_d.asel = ADDR_STRAP;
      s_d.multifunction_pin_0 = MODE_SPI | ADDR_STRAP[0];
      s_d.multifunction_pin_1 = !MODE_SPI & ADDR_STRAP[1];
      s_d.el = EL_STOP;
      s_d.ph = 2'h3;
      s_d.miso2 = 1'b1;
      s_d.sda1 = 1'b1;
      s_d.sda2 = 1'b1;
      s_d.scl1 = 1'b1;
      s_d.scl2 = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    s_q <= s_d;
  end

  assign CMD_READY = s_q.ready;
  assign RSP = s_q.rsp;
  assign PAGE_SEL = s_q.page;
  assign SELECT_PIN = s_q.spi;
  assign MULTIFUNCTION_PIN_0 = s_q.multifunction_pin_0;
  assign MULTIFUNCTION_PIN_1 = s_q.multifunction_pin_1;
  assign MULTIFUNCTION_PIN_3 = s_q.multifunction_pin_3;
  assign SCL_O = s_q.lo;
  assign SDA_O = s_q.lo;
  assign SCL_OE = s_q.scl_oe;
  assign SDA_OE = s_q.sda_oe;

  // select-high time and clock edges per frame
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      hgap_q <= 10'(`DSCP_CS_GAP_CYC);
      hedge_q <= 5'h00;
    end else begin
      if (!MULTIFUNCTION_PIN_0) hgap_q <= 10'h000;
      else if (hgap_q != 10'h3ff) hgap_q <= hgap_q + 10'h001;
      if (MULTIFUNCTION_PIN_0) hedge_q <= 5'h00;
      else if (s_d.multifunction_pin_1 && !s_q.multifunction_pin_1) hedge_q <= hedge_q + 5'h01;
    end
  end

  default clocking dscp_cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  AST_SELECT_STATIC: assert property (!$past(RESET) |-> $stable(SELECT_PIN))
    else $error("select pin changed while running");
  AST_SCLK_IDLE_LOW: assert property (SELECT_PIN && MULTIFUNCTION_PIN_0 |->
    !MULTIFUNCTION_PIN_1) else $error("spi clock high outside a frame");
  AST_MOSI_ON_RISE: assert property (SELECT_PIN && $changed(MULTIFUNCTION_PIN_3) |->
    $rose(MULTIFUNCTION_PIN_1)) else $error("mosi moved off the rising edge");
  AST_SPI_SIXTEEN: assert property (SELECT_PIN && $rose(MULTIFUNCTION_PIN_0) |->
    hedge_q == `DSCP_SPI_BITS) else $error("spi frame not sixteen clocks");
  AST_CMD_ADDR_FIRST: assert property (SELECT_PIN && s_q.fsm == S_SPI_BIT
    && $rose(MULTIFUNCTION_PIN_1) && s_q.bitn == 5'h00
    |-> MULTIFUNCTION_PIN_3 == s_q.cmd.addr[6]) else $error("command not address first");
  AST_CMD_DIR_LAST: assert property (SELECT_PIN && s_q.fsm == S_SPI_BIT
    && $rose(MULTIFUNCTION_PIN_1) && s_q.bitn == 5'h07
    |-> MULTIFUNCTION_PIN_3 == s_q.cmd.rd) else $error("direction flag not eighth bit");
  AST_CS_GAP: assert property (SELECT_PIN && $fell(MULTIFUNCTION_PIN_0) |->
    hgap_q >= 10'(`DSCP_CS_GAP_CYC)) else $error("chip select gap too short");
  // i2c lines quiet in spi mode
  AST_I2C_QUIET: assert property (SELECT_PIN |-> !SCL_OE && !SDA_OE)
    else $error("i2c line pulled in spi mode");
  AST_SDA_SCL_LOW: assert property (!SELECT_PIN && s_q.el == EL_BYTE
    && $changed(SDA_OE) |-> SCL_OE) else $error("sda moved with scl high");
  AST_ACK_RELEASED: assert property (!SELECT_PIN && s_q.fsm == S_I2C_EL
    && s_q.el == EL_BYTE && s_q.bitn == `DSCP_ACK_BIT && s_q.ph != 2'h0 |-> !SDA_OE)
    else $error("host pulled sda in the ack slot");
  AST_DEV_ADDR: assert property (s_q.fsm == S_I2C_EL && s_q.el == EL_BYTE
    && s_q.step == 3'h1 && s_q.bitn == 5'h00 && !s_q.cmd.gcall
    |-> s_q.sh[15:9] == {`DSCP_DEV_HI, s_q.asel}) else $error("wrong slave address");
  AST_PAGE_TRACK: assert property (RSP.valid && !RSP.nack && !s_q.cmd.rd
    && !s_q.cmd.gcall && s_q.cmd.addr == `DSCP_PAGE_REG |-> PAGE_SEL == s_q.cmd.wdata[0])
    else $error("page not updated");

endmodule : dscp_host

// ===== testbench/dscp_codec.sv
// behavioural codec control port, SPI and I2C slave
`timescale 1ns/1ps
module dscp_codec (
  input wire logic sel,
  input wire logic [1:0] pins,
  input wire logic slow,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso = 1'b0,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pl = 1'b0,
  output logic sda_pl = 1'b0
);
  logic [7:0] mem [256];
  logic [15:0] sr;
  logic [7:0] dat;
  logic [6:0] ptr;
  logic pg = 1'b0, rd, ia = 1'b0, ma, ak;
  int n, bn, st = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  function automatic logic [7:0] get(logic [6:0] a);
    return (a == 7'h00) ? {7'h00, pg} : mem[{pg, a}];
  endfunction : get
  task automatic put(logic [6:0] a, logic [7:0] d);
    if (a == 7'h00) pg = d[0];
    else mem[{pg, a}] = d;
  endtask : put
  always @(negedge cs_n) n = 0;
  always @(posedge cs_n) miso = ~miso;
  // drive on rise, data in second byte
  always @(posedge sck) if (sel && !cs_n) miso = (n > 7 && rd) ? dat[15-n] : ~miso;
  // sample on fall, address then direction
  always @(negedge sck) begin
    if (sel && !cs_n) begin
      sr = {sr[14:0], mosi};
      n++;
      if (n == 8) rd = sr[0];
      if (n == 8) dat = get(sr[7:1]);
      if (n == 16 && !rd) put(sr[15:9], sr[7:0]);
    end
  end
  always @(negedge sda) begin
    if (!sel && scl) begin
      st = 1;
      bn = 0;
      ia = 1'b0;
    end
  end
  always @(posedge sda) if (!sel && scl) st = 0;
  // shift on rise, master ack on ninth
  always @(posedge scl) begin
    if (!sel && st != 0 && bn < 8) begin
      sr[7:0] = {sr[6:0], sda};
      bn++;
    end else if (!sel && st != 0) ma = !sda;
  end
  always @(negedge scl) begin
    if (!sel && st != 0) begin
      if (ia) begin
        ia = 1'b0;
        bn = 0;
        sda_pl = 1'b0;
        if (st == 4 && !ma) st = 5;
        if (st == 4) dat = get(ptr);
        if (st == 4) ptr++;
        if (st == 4) sda_pl = !dat[7];
      end else if (bn == 8) begin
        ia = 1'b1;
        ak = (st == 2) || (st == 3) || (st == 6) ||
          ((st == 1) && (sr[7:1] == {5'h06, pins} || sr[7:0] == 8'h00));
        if (st == 3) put(ptr, sr[7:0]);
        if (st == 3) ptr++;
        if (st == 2) ptr = sr[6:0];
        if (st == 2) st = 3;
        else if (st == 1 && ak) st = (sr[7:0] == 8'h00) ? 6 : (sr[0] ? 4 : 2);
        else if (st == 1) st = 5;
        sda_pl = ak;
      end else if (st == 4) sda_pl = !dat[7-bn];
      if (slow) begin
        scl_pl = 1'b1;
        #2500;
        scl_pl = 1'b0;
      end
    end
  end
endmodule : dscp_codec

// ===== testbench/tb.sv
// self-checking bench for the codec port host
`timescale 1ns/1ps
module tb;
  import dscp_pkg::*;
  typedef struct packed {
    logic rd;
    logic nk;
    logic [7:0] d;
  } dscp_exp_type;
  logic mclk = 1'b0, reset = 1'b1, spi = 1'b1, valid = 1'b0, slow = 1'b0;
  logic [1:0] strap = 2'h0, flip = 2'h0;
  dscp_cmd_type cmd = '0;
  dscp_rsp_type rsp;
  logic ready, page, selp, cs, sck, miso, mosi, scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda;
  logic cs_q = 1'b1, mosi_q = 1'b0, sck_q = 1'b0, pg = 1'b0;
  logic [7:0] rnd = 8'h27;
  logic [7:0] shadow [256];
  dscp_exp_type expq [$];
  int fail_count = 0, checks = 0, cyc = 0, gap = 0;
  wire scl = !(scl_oe || m_scl);
  wire sda = !(sda_oe || m_sda);
  always #5 mclk = ~mclk;
  dscp_host u_dut (.MCLK(mclk), .RESET(reset), .MODE_SPI(spi), .ADDR_STRAP(strap),
    .CMD_VALID(valid), .CMD(cmd), .CMD_READY(ready), .RSP(rsp), .PAGE_SEL(page),
    .SELECT_PIN(selp), .MULTIFUNCTION_PIN_0(cs), .MULTIFUNCTION_PIN_1(sck),
    .MULTIFUNCTION_PIN_2(miso), .MULTIFUNCTION_PIN_3(mosi), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));
  dscp_codec u_codec (.sel(selp), .pins({sck, cs} ^ flip), .slow(slow), .cs_n(cs),
    .sck(sck), .mosi(mosi), .miso(miso), .scl(scl), .sda(sda), .scl_pl(m_scl), .sda_pl(m_sda));
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check8(logic [7:0] got, logic [7:0] exp, string m);
    checks++;
    if (got !== exp) fail_count++;
    if (got !== exp) $display("BAD %0t %s got %h want %h", $time, m, got, exp);
  endtask : check8
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic send(logic r, logic g, logic [6:0] a, logic [7:0] d, logic nk = 1'b0);
    for (int i = 0; i < 30000 && ready !== 1'b1; i++) @(posedge mclk);
    expq.push_back('{r, nk, (a == 7'h00) ? {7'h00, pg} : shadow[{pg, a}]});
    if (!r && !g && !nk && a == 7'h00) pg = d[0];
    else if (!r && !g && !nk) shadow[{pg, a}] = d;
    valid <= 1'b1;
    cmd <= '{r, g, a, d};
    @(posedge mclk);
    // second request while busy must be dropped
    cmd <= '{!r, g, ~a, ~d};
    repeat (3) @(posedge mclk);
    valid <= 1'b0;
    @(posedge mclk);
  endtask : send
  task automatic drain();
    for (int i = 0; i < 30000 && expq.size() > 0; i++) @(posedge mclk);
    check8(8'(expq.size()), 8'h00, "lost reply");
    @(posedge mclk);
  endtask : drain
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 70000) begin
      fail_count++;
      summarize();
    end
  end
  always @(posedge mclk) begin
    dscp_exp_type e;
    if (!reset && rsp.valid === 1'b1) begin
      if (expq.size() == 0) check8(8'h01, 8'h00, "extra reply");
      else begin
        e = expq.pop_front();
        check8({7'h00, rsp.nack}, {7'h00, e.nk}, "ack");
        if (e.rd) check8(rsp.rdata, e.d, "rdata");
      end
    end
    if (!reset && selp === 1'b1) begin
      // 6.25us at 10ns
      if (cs_q && !cs) check8({7'h00, gap > 624}, 8'h01, "cs gap");
      if (!cs && mosi !== mosi_q) check8({7'h00, sck & ~sck_q}, 8'h01, "mosi edge");
      if (cs) check8({7'h00, sck}, 8'h00, "sclk idle");
      gap = cs ? gap + 1 : 0;
    end
    cs_q = cs;
    mosi_q = mosi;
    sck_q = sck;
  end
  initial begin
    logic [6:0] a;
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'hA5;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check8({5'h00, selp, page, cs}, 8'h05, "spi idle");
    for (int k = 0; k < 5; k++) begin
      rnd = lfsr(rnd);
      a = (k == 0 || rnd[6:0] == 7'h00) ? 7'h7F : rnd[6:0];
      rnd = lfsr(rnd);
      send(0, 0, a, rnd);
      send(1, 0, a, 8'h00);
    end
    send(0, 0, 7'h00, 8'h01);
    drain();
    check8({7'h00, page}, 8'h01, "page");
    send(1, 0, 7'h00, 8'h00);
    send(0, 0, 7'h05, 8'h3C);
    send(1, 0, 7'h05, 8'h00);
    send(0, 0, 7'h00, 8'h00);
    send(1, 0, 7'h05, 8'h00);
    drain();
    // select level moves only under reset
    reset <= 1'b1;
    spi <= 1'b0;
    strap <= rnd[1:0];
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check8({2'h0, selp, scl_o, sda_o, page, sck, cs}, {6'h00, strap}, "i2c idle");
    send(0, 0, 7'h21, rnd);
    send(0, 1, 7'h21, 8'h77);
    drain();
    flip <= 2'h1;
    send(0, 0, 7'h22, 8'h99, 1'b1);
    drain();
    flip <= 2'h0;
    slow <= 1'b1;
    send(1, 0, 7'h21, 8'h00);
    drain();
    summarize();
  end
endmodule : tb
